// *** uas_sequencer.sv ***
// Purpose: Playback, capture and suspend sequencing of a USB audio function
// Assumes: Packet decoding is upstream; strobes are one-cycle pulses
// Notes:   Rules carried out by this block are listed below
// Functional notes
// - Playback starts on the SOF after priming
// - On host stop while playing, drain buffer then stop
// - Capture writes begin after recording interface selected
// - Enter suspend after 5 ms idle bus
// - Suspend indicator asserted while suspended
// - Leave suspend immediately on bus activity
// - Buffer first 1 ms packet before playing
// - Output bipolar zero while waiting for data
// - Internal reset held about 700 us
`timescale 1ns/10ps
module uas_sequencer #(
    parameter int IDLE_LIMIT = uas_pkg::IDLE_CYCLES,
    parameter int POR_LIMIT  = uas_pkg::POR_CYCLES
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          busIdle,
    input  wire logic                          sofStrobe,
    input  wire logic                          pktEnd,
    input  wire logic                          playStop,
    input  wire logic                          recSelect,
    input  wire logic                          recDeselect,
    input  wire logic                          sampleTick,
    input  wire logic [uas_pkg::FILL_W-1:0]    bufLevel,
    input  wire logic [uas_pkg::SAMPLE_W-1:0]  bufSample,
    output logic                               bufPop,
    output logic [uas_pkg::SAMPLE_W-1:0]       dacSample,
    output logic                               playActive,
    output logic                               capWriteEn,
    output logic                               suspend_indicator_out,
    output logic                               sysRst_n
);
    import uas_pkg::*;

    // ----------------------------------------------------------------
    // Internal reset stretcher
    // ----------------------------------------------------------------
    logic intRst_n;                     // Stretched reset for all logic

    uas_por_stretch #(
        .HOLD_CYCLES (POR_LIMIT)
    ) u_por (
        .clk      (clk),
        .rst_n    (rst_n),
        .intRst_n (intRst_n)
    );

    assign sysRst_n = intRst_n;

    // ----------------------------------------------------------------
    // Playback state
    // ----------------------------------------------------------------
    uas_pb_e               pbState_ff;  // Playback sequencing state
    uas_pb_e               nxt_pbState;
    logic [SAMPLE_W-1:0]   dac_ff;      // Sample presented to converter
    logic [SAMPLE_W-1:0]   nxt_dac;

    function automatic logic bufEmpty(input logic [FILL_W-1:0] lvl);
        return lvl == FILL_ZERO;
    endfunction

    // Playback next-state logic
    always_comb
    begin
        nxt_pbState = pbState_ff;
        nxt_dac     = dac_ff;
        bufPop      = 1'b0;
        case (pbState_ff)
            UAS_PB_IDLE:
            begin
                nxt_dac = BPZ_CODE;
                // First full packet stored before anything plays
                if (pktEnd)
                    nxt_pbState = UAS_PB_PRIME;
            end
            UAS_PB_PRIME:
            begin
                nxt_dac = BPZ_CODE;
                // Start output on the next frame start
                if (playStop && bufEmpty(bufLevel))
                    nxt_pbState = UAS_PB_IDLE;
                else if (sofStrobe)
                    nxt_pbState = UAS_PB_PLAY;
            end
            UAS_PB_PLAY:
            begin
                if (sampleTick && !bufEmpty(bufLevel))
                begin
                    bufPop  = 1'b1;
                    nxt_dac = bufSample;
                end
                // Host stop: keep playing what is buffered
                if (playStop)
                    nxt_pbState = UAS_PB_DRAIN;
            end
            UAS_PB_DRAIN:
            begin
                // Stop only once every buffered sample is out
                if (bufEmpty(bufLevel))
                begin
                    nxt_pbState = UAS_PB_IDLE;
                    nxt_dac     = BPZ_CODE;
                end
                else if (sampleTick)
                begin
                    bufPop  = 1'b1;
                    nxt_dac = bufSample;
                end
            end
            default:
                nxt_pbState = UAS_PB_IDLE;
        endcase
    end

    // Playback registers
    always_ff @(posedge clk or negedge intRst_n)
    begin
        if (!intRst_n)
        begin
            pbState_ff <= UAS_PB_IDLE;
            dac_ff     <= BPZ_CODE;
        end
        else
        begin
            pbState_ff <= nxt_pbState;
            dac_ff     <= nxt_dac;
        end
    end

    assign dacSample  = dac_ff;
    assign playActive = (pbState_ff == UAS_PB_PLAY) || (pbState_ff == UAS_PB_DRAIN);

    // ----------------------------------------------------------------
    // Capture enable
    // ----------------------------------------------------------------
    logic capEn_ff;                     // Recording interface selected
    logic nxt_capEn;

    // Capture writes start only after the interface selection
    always_comb
    begin
        nxt_capEn = capEn_ff;
        if (recSelect)
            nxt_capEn = 1'b1;
        else if (recDeselect)
            nxt_capEn = 1'b0;
    end

    always_ff @(posedge clk or negedge intRst_n)
    begin
        if (!intRst_n)
            capEn_ff <= 1'b0;
        else
            capEn_ff <= nxt_capEn;
    end

    assign capWriteEn = capEn_ff;

    // ----------------------------------------------------------------
    // Suspend detection
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] idleCnt_ff;       // Continuous idle cycles
    logic [CNT_W-1:0] nxt_idleCnt;
    logic             susp_ff;          // Suspend state
    logic             nxt_susp;

    // Idle counter and suspend flag
    always_comb
    begin
        nxt_idleCnt = idleCnt_ff;
        nxt_susp    = susp_ff;
        if (!busIdle)
        begin
            // Any activity wakes at once and restarts the count
            nxt_idleCnt = '0;
            nxt_susp    = 1'b0;
        end
        else if (idleCnt_ff >= CNT_W'(IDLE_LIMIT - 1))
            nxt_susp = 1'b1;
        else
            nxt_idleCnt = idleCnt_ff + CNT_W'(1);
    end

    always_ff @(posedge clk or negedge intRst_n)
    begin
        if (!intRst_n)
        begin
            idleCnt_ff <= '0;
            susp_ff    <= 1'b0;
        end
        else
        begin
            idleCnt_ff <= nxt_idleCnt;
            susp_ff    <= nxt_susp;
        end
    end

    // Indicator follows the suspend state
    assign suspend_indicator_out = susp_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_play_on_sof: assert property (@(posedge clk) disable iff (!intRst_n)
        $rose(playActive) |-> $past(pbState_ff) == UAS_PB_PRIME && $past(sofStrobe))
        else $error("playback started without SOF");
    a_prime_needs_pkt: assert property (@(posedge clk) disable iff (!intRst_n)
        (pbState_ff == UAS_PB_IDLE && pktEnd) |=> pbState_ff == UAS_PB_PRIME)
        else $error("first packet not primed");
    a_drain_till_empty: assert property (@(posedge clk) disable iff (!intRst_n)
        (pbState_ff == UAS_PB_DRAIN && !bufEmpty(bufLevel)) |=> playActive)
        else $error("playback stopped with data left");
    a_idle_outputs_bpz: assert property (@(posedge clk) disable iff (!intRst_n)
        (pbState_ff == UAS_PB_IDLE) |=> (pbState_ff != UAS_PB_IDLE) || dacSample == BPZ_CODE)
        else $error("idle output not bipolar zero");
    a_capture_gated: assert property (@(posedge clk) disable iff (!intRst_n)
        $rose(capWriteEn) |-> $past(recSelect))
        else $error("capture began without selection");
    a_suspend_entry: assert property (@(posedge clk) disable iff (!intRst_n)
        $rose(susp_ff) |-> $past(idleCnt_ff) == CNT_W'(IDLE_LIMIT - 1) && $past(busIdle))
        else $error("suspend entered early");
    a_wake_now: assert property (@(posedge clk) disable iff (!intRst_n)
        !busIdle |=> !suspend_indicator_out)
        else $error("wake-up delayed");
    a_indicator_state: assert property (@(posedge clk) disable iff (!intRst_n)
        (suspend_indicator_out && busIdle) |=> suspend_indicator_out)
        else $error("indicator dropped while still suspended");

    c_playback: cover property (@(posedge clk) disable iff (!intRst_n)
        pbState_ff == UAS_PB_DRAIN ##1 pbState_ff == UAS_PB_IDLE);
    c_capture: cover property (@(posedge clk) disable iff (!intRst_n) $rose(capWriteEn));
    c_suspend: cover property (@(posedge clk) disable iff (!intRst_n) $rose(susp_ff));
    c_resume: cover property (@(posedge clk) disable iff (!intRst_n) $fell(susp_ff));

endmodule

// *** uas_pkg.sv ***
// Purpose: Shared constants and types for the USB audio stream sequencer
// Assumes: Single 200 MHz clock domain
// Notes:   Times are kept in their own unit; cycle counts derive from them
package uas_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ          = 200;          // Core clock rate
    localparam int IDLE_SUSPEND_US  = 5000;         // Bus idle time before suspend
    localparam int POR_HOLD_US      = 700;          // Internal reset stretch
    localparam int IDLE_CYCLES      = IDLE_SUSPEND_US * CLK_MHZ;
    localparam int POR_CYCLES       = POR_HOLD_US * CLK_MHZ;
    localparam int CNT_W            = 21;           // Counter width for long waits

    // ----------------------------------------------------------------
    // Stream data
    // ----------------------------------------------------------------
    localparam int SAMPLE_W         = 16;           // Audio sample width
    localparam int FILL_W           = 8;            // Buffered sample count width
    localparam logic [SAMPLE_W-1:0] BPZ_CODE = 16'h0000; // Bipolar zero
    localparam logic [FILL_W-1:0]   FILL_ZERO = 8'h00;   // Empty buffer level

    // ----------------------------------------------------------------
    // Playback sequencing states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        UAS_PB_IDLE  = 4'b0001,    // Configured, waiting for data
        UAS_PB_PRIME = 4'b0010,    // First packet buffered, waiting for SOF
        UAS_PB_PLAY  = 4'b0100,    // Outputting samples
        UAS_PB_DRAIN = 4'b1000     // Host stopped, emptying buffer
    } uas_pb_e;

endpackage

// *** uas_por_stretch.sv ***
// Purpose: Holds the internal reset low for a fixed time after power-on
// Assumes: rst_n is the raw power-on detector output
// Notes:   Count is a parameter so simulation can shorten it
`timescale 1ns/10ps
module uas_por_stretch #(
    parameter int HOLD_CYCLES = uas_pkg::POR_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      intRst_n
);
    import uas_pkg::*;

    logic [CNT_W-1:0] holdCnt_ff;       // Cycles since power-on release
    logic [CNT_W-1:0] nxt_holdCnt;
    logic             relDone_ff;       // Reset stretch finished
    logic             nxt_relDone;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_holdCnt = holdCnt_ff;
        nxt_relDone = relDone_ff;
        // Count up until the hold time has elapsed
        if (!relDone_ff)
        begin
            if (holdCnt_ff >= CNT_W'(HOLD_CYCLES - 1))
                nxt_relDone = 1'b1;
            else
                nxt_holdCnt = holdCnt_ff + CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            holdCnt_ff <= '0;
            relDone_ff <= 1'b0;
        end
        else
        begin
            holdCnt_ff <= nxt_holdCnt;
            relDone_ff <= nxt_relDone;
        end
    end

    assign intRst_n = relDone_ff;

    // Reset is released exactly HOLD_CYCLES edges after power-on
    a_por_hold_time: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(relDone_ff) |-> $past(holdCnt_ff) == CNT_W'(HOLD_CYCLES - 1))
        else $error("internal reset released at wrong count");

endmodule

// *** uas_host_model.sv ***
// Purpose: Far-side model: host traffic strobes plus the external playback buffer
// Assumes: Drives everything at the falling clock edge
// Notes:   Buffer head sample is 0xa5 in the high byte, fill level in the low byte
`timescale 1ns/10ps
module uas_host_model (
    input  wire logic                      clk,
    input  wire logic                      bufPop,
    output logic                           busIdle,
    output logic                           sofStrobe,
    output logic                           pktEnd,
    output logic                           playStop,
    output logic                           recSelect,
    output logic                           recDeselect,
    output logic [uas_pkg::FILL_W-1:0]     bufLevel,
    output logic [uas_pkg::SAMPLE_W-1:0]   bufSample
);
    import uas_pkg::*;
    // ----------------------------------------------------------------
    // Buffer state and pending host requests
    // ----------------------------------------------------------------
    logic [FILL_W-1:0] levelQ    = FILL_ZERO;   // Samples held
    logic [FILL_W-1:0] fillReq   = FILL_ZERO;   // Packet size to store next
    logic [3:0]        strobeReq = 4'h0;        // Deselect, select, stop, SOF
    logic              idleReq   = 1'b0;        // Bus line state to show next
    logic              popSeen   = 1'b0;        // Pop taken at last rising edge
    assign bufLevel  = levelQ;
    assign bufSample = {8'ha5, levelQ};
    // Pop is taken at the rising edge, level drops at the next falling edge
    always @(posedge clk) popSeen <= bufPop;
    // Every model output changes here, one falling edge after its request
    always @(negedge clk)
    begin
        {recDeselect, recSelect, playStop, sofStrobe} <= strobeReq;
        pktEnd  <= (fillReq != FILL_ZERO);
        busIdle <= idleReq;
        if (fillReq != FILL_ZERO)
            levelQ <= fillReq;
        else if (popSeen && levelQ != FILL_ZERO)
            levelQ <= levelQ - 8'h01;
    end
    // ----------------------------------------------------------------
    // Host actions
    // ----------------------------------------------------------------
    // One-cycle strobe: 0 SOF, 1 stop, 2 record select, 3 record deselect
    task automatic strobe(input int which);
        @(negedge clk);
        case (which)
            0: strobeReq <= 4'b0001;
            1: strobeReq <= 4'b0010;
            2: strobeReq <= 4'b0100;
            default: strobeReq <= 4'b1000;
        endcase
        @(negedge clk);
        strobeReq <= 4'h0;
        @(negedge clk);
    endtask
    // One packet of n samples lands in the buffer with its end strobe
    task automatic sendPkt(input logic [FILL_W-1:0] n);
        @(negedge clk);
        fillReq <= n;
        @(negedge clk);
        fillReq <= FILL_ZERO;
        @(negedge clk);
    endtask
    // Bus line state, J idle when high; returns as the new state shows
    task automatic setIdle(input logic b);
        @(negedge clk);
        idleReq <= b;
        @(negedge clk);
    endtask
endmodule

// *** tb_usb_audio_stream_sequencer.sv ***
// Purpose: Self-checking bench for the audio stream sequencer
// Assumes: Shortened idle and reset counts through parameters
// Notes:   Inputs change at the falling edge, outputs are judged there too
`timescale 1ns/10ps
module tb_usb_audio_stream_sequencer;
    import uas_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int IDLE_N = 50;               // Idle cycles before suspend
    localparam int POR_N  = 20;               // Internal reset stretch
    logic clk = 1'b0, rst_n = 1'b0, sampleTick = 1'b0;
    logic busIdle, sofStrobe, pktEnd, playStop, recSelect, recDeselect;
    logic bufPop, playActive, capWriteEn, suspend_indicator_out, sysRst_n;
    logic [FILL_W-1:0]   bufLevel;
    logic [SAMPLE_W-1:0] bufSample, dacSample;
    int fails = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    uas_host_model host_u (.clk(clk), .bufPop(bufPop), .busIdle(busIdle),
        .sofStrobe(sofStrobe), .pktEnd(pktEnd), .playStop(playStop),
        .recSelect(recSelect), .recDeselect(recDeselect), .bufLevel(bufLevel),
        .bufSample(bufSample));
    uas_sequencer #(.IDLE_LIMIT(IDLE_N), .POR_LIMIT(POR_N)) dut_u (.clk(clk),
        .rst_n(rst_n), .busIdle(busIdle), .sofStrobe(sofStrobe), .pktEnd(pktEnd),
        .playStop(playStop), .recSelect(recSelect), .recDeselect(recDeselect),
        .sampleTick(sampleTick), .bufLevel(bufLevel), .bufSample(bufSample),
        .bufPop(bufPop), .dacSample(dacSample), .playActive(playActive),
        .capWriteEn(capWriteEn), .suspend_indicator_out(suspend_indicator_out),
        .sysRst_n(sysRst_n));
    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic chk1(input logic got, input logic exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One converter request; pop in the same cycle, sample one edge later
    task automatic tick(input logic [15:0] exp);
        @(negedge clk);
        sampleTick <= 1'b1;
        #1 chk1(bufPop, 1'b1, "no pop on tick");
        @(negedge clk);
        sampleTick <= 1'b0;
        chk16(dacSample, exp, "converter sample");
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        int n;
        repeat (10) @(negedge clk);
        chk1(sysRst_n, 1'b0, "reset not held");
        chk16(dacSample, BPZ_CODE, "output not zero in reset");
        rst_n = 1'b1;
        n = 0;
        while (sysRst_n !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk1(n >= POR_N - 1 && n <= POR_N + 2, 1'b1, "reset stretch length");
        if (sysRst_n !== 1'b1)
            end_of_test;
        $display("reset test done");
    endtask
    task automatic test_playback;
        int n;
        host_u.strobe(0);
        chk1(playActive, 1'b0, "started without data");
        host_u.sendPkt(8'h04);
        repeat (3) @(negedge clk);
        chk1(playActive, 1'b0, "started before frame start");
        chk16(dacSample, BPZ_CODE, "output not zero while primed");
        host_u.strobe(0);
        chk1(playActive, 1'b1, "no start on frame start");
        tick(16'ha504);
        tick(16'ha503);
        host_u.strobe(1);
        chk1(playActive, 1'b1, "stopped before drained");
        tick(16'ha502);
        tick(16'ha501);
        n = 0;
        while (playActive !== 1'b0 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        chk1(n < 10, 1'b1, "drain never ended");
        if (n >= 10)
            end_of_test;
        chk16(dacSample, BPZ_CODE, "output not zero after drain");
        sampleTick <= 1'b1;
        #1 chk1(bufPop, 1'b0, "pop while stopped");
        @(negedge clk);
        sampleTick <= 1'b0;
        $display("playback test done");
    endtask
    task automatic test_capture;
        chk1(capWriteEn, 1'b0, "capture before select");
        host_u.strobe(2);
        chk1(capWriteEn, 1'b1, "capture not enabled");
        host_u.strobe(3);
        chk1(capWriteEn, 1'b0, "capture not disabled");
        $display("capture test done");
    endtask
    task automatic test_suspend;
        host_u.setIdle(1'b1);
        repeat (IDLE_N - 5) @(negedge clk);
        chk1(suspend_indicator_out, 1'b0, "early suspend");
        host_u.setIdle(1'b0);
        host_u.setIdle(1'b1);
        repeat (IDLE_N - 2) @(negedge clk);
        chk1(suspend_indicator_out, 1'b0, "idle count not restarted");
        repeat (5) @(negedge clk);
        chk1(suspend_indicator_out, 1'b1, "no suspend after idle");
        repeat (20) @(negedge clk);
        chk1(suspend_indicator_out, 1'b1, "indicator not held");
        host_u.setIdle(1'b0);
        @(negedge clk);
        chk1(suspend_indicator_out, 1'b0, "slow wake-up");
        $display("suspend test done");
    endtask
    initial
    begin
        test_reset;
        test_playback;
        test_capture;
        test_suspend;
        end_of_test;
    end
endmodule
